// >>> core/oms_pkg.sv
/*
 * oms_pkg: constants and carrier types for the operation mode selector.
 * Assumes setting values arrive already range-checked by the parameter
 * store; unlisted operation-mode codes simply fall through to "hold mode".
 */
package oms_pkg;

    // drive operation modes; the external mode is the power-up default
    typedef enum logic [1:0]
    {
        OMS_EXTERNAL,
        OMS_PANEL,
        OMS_NETWORK,
        OMS_COMBINED
    } oms_mode_t;

    localparam int OM_W = 3;
    localparam int SU_W = 4;
    localparam int SRC_W = 4;
    localparam int TERM_N = 7;
    localparam int SEL_W = 8;

    // operation-mode setting values
    localparam logic [OM_W-1:0] OM_SWITCHABLE = 3'h0;
    localparam logic [OM_W-1:0] OM_PANEL_FIXED = 3'h1;
    localparam logic [OM_W-1:0] OM_EXT_FIXED = 3'h2;
    localparam logic [OM_W-1:0] OM_COMB_A = 3'h3;
    localparam logic [OM_W-1:0] OM_COMB_B = 3'h4;
    localparam logic [OM_W-1:0] OM_RUN_SWITCH = 3'h6;
    localparam logic [OM_W-1:0] OM_INTERLOCK = 3'h7;

    // startup-mode setting values
    localparam logic [SU_W-1:0] SU_AS_SET = 4'h0;
    localparam logic [SU_W-1:0] SU_NETWORK = 4'h1;
    localparam logic [SU_W-1:0] SU_NET_PANEL = 4'hA;

    // network command source: communication option
    localparam logic [SRC_W-1:0] SRC_OPTION = 4'h0;

    // terminal function codes
    localparam logic [SEL_W-1:0] FN_INTERLOCK = 8'h0C;
    localparam logic [SEL_W-1:0] FN_PANEL_EXT = 8'h10;
    localparam logic [SEL_W-1:0] FN_NET_PANEL = 8'h41;
    localparam logic [SEL_W-1:0] FN_NET_EXT = 8'h42;

    // reset values
    localparam oms_mode_t MODE_RST = OMS_EXTERNAL;
    localparam logic [TERM_N:0] SYNC_RST = 8'h00;

    // parameter settings that steer the selector
    typedef struct packed
    {
        logic [OM_W-1:0] operation_mode_setting;
        logic [SU_W-1:0] startup_mode_setting;
        logic [SRC_W-1:0] net_command_source_setting;
        logic option_fitted;
    } oms_settings_t;

endpackage : oms_pkg

// >>> core/oms_mode_select.sv
/*
 * oms_mode_select: picks the drive operation mode from the settings,
 * the terminal function selectors and the assignable input terminals.
 * Assumes the terminals and the output-stop pin are asynchronous pins,
 * and that motor-running and start-command come from same-clock logic.
 */
`timescale 1ns/1ps

module oms_mode_select
(
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    input wire oms_pkg::oms_settings_t i_settings,
    input wire logic [oms_pkg::TERM_N-1:0][oms_pkg::SEL_W-1:0] i_term_sel,
    input wire logic [oms_pkg::TERM_N-1:0] i_term_pins,
    input wire logic i_output_stop_pin,
    input wire logic i_motor_running,
    input wire logic i_start_cmd,
    output oms_pkg::oms_mode_t o_mode,
    output logic o_output_stop,
    output logic o_switch_open
);

    logic [oms_pkg::TERM_N:0] sync1_reg;
    logic [oms_pkg::TERM_N:0] sync1_next;
    logic [oms_pkg::TERM_N:0] sync2_reg;
    logic [oms_pkg::TERM_N:0] sync2_next;
    oms_pkg::oms_mode_t mode_reg;
    oms_pkg::oms_mode_t mode_next;
    oms_pkg::oms_mode_t target;
    logic stop_reg;
    logic stop_next;
    logic np_asg, np_on, ne_asg, ne_on, pe_asg, pe_on, il_asg, il_pin;
    logic il_on, stopped, forced, active, take, no_option;
    logic om_net_ok, om_np_ok, np_act, ne_act;
    logic [oms_pkg::OM_W-1:0] om;
    logic [oms_pkg::SU_W-1:0] su;

    assign om = i_settings.operation_mode_setting;
    assign su = i_settings.startup_mode_setting;

    // two-stage synchroniser; stage one feeds only stage two
    always_comb
    begin
        sync1_next = {i_output_stop_pin, i_term_pins};
        sync2_next = sync1_reg;
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
        begin
            sync1_reg <= oms_pkg::SYNC_RST;
            sync2_reg <= oms_pkg::SYNC_RST;
        end
        else
        begin
            sync1_reg <= sync1_next;
            sync2_reg <= sync2_next;
        end
    end

    // route each function to whichever terminal selects its code
    always_comb
    begin
        np_asg = 1'b0;
        np_on = 1'b0;
        ne_asg = 1'b0;
        ne_on = 1'b0;
        pe_asg = 1'b0;
        pe_on = 1'b0;
        il_asg = 1'b0;
        il_pin = 1'b0;
        for (int i = 0; i < oms_pkg::TERM_N; i++)
        begin
            if (i_term_sel[i] == oms_pkg::FN_NET_PANEL)
            begin
                np_asg = 1'b1;
                np_on = np_on | sync2_reg[i];
            end
            if (i_term_sel[i] == oms_pkg::FN_NET_EXT)
            begin
                ne_asg = 1'b1;
                ne_on = ne_on | sync2_reg[i];
            end
            if (i_term_sel[i] == oms_pkg::FN_PANEL_EXT)
            begin
                pe_asg = 1'b1;
                pe_on = pe_on | sync2_reg[i];
            end
            if (i_term_sel[i] == oms_pkg::FN_INTERLOCK)
            begin
                il_asg = 1'b1;
                il_pin = il_pin | sync2_reg[i];
            end
        end
    end

    // without a terminal for it, the output-stop pin acts as interlock
    assign il_on = il_asg ? il_pin : sync2_reg[oms_pkg::TERM_N];
    assign stopped = !i_motor_running || !i_start_cmd;
    assign no_option = (i_settings.net_command_source_setting ==
                        oms_pkg::SRC_OPTION) && !i_settings.option_fitted;
    assign om_np_ok = (om == oms_pkg::OM_SWITCHABLE) ||
                      (om == oms_pkg::OM_RUN_SWITCH) ||
                      (om == oms_pkg::OM_INTERLOCK);
    assign om_net_ok = om_np_ok || (om == oms_pkg::OM_EXT_FIXED);
    // interlock off in setting 7 disables both network inputs
    assign ne_act = ne_asg && om_net_ok &&
                    (su == oms_pkg::SU_AS_SET || su == oms_pkg::SU_NETWORK) &&
                    !(om == oms_pkg::OM_INTERLOCK && !il_on);
    assign np_act = np_asg && om_np_ok &&
                    (su == oms_pkg::SU_NET_PANEL) &&
                    !(om == oms_pkg::OM_INTERLOCK && !il_on);

    // target mode, highest-priority source first
    always_comb
    begin
        target = mode_reg;
        forced = 1'b0;
        active = 1'b0;
        if (om == oms_pkg::OM_PANEL_FIXED)
        begin
            target = oms_pkg::OMS_PANEL;
            forced = 1'b1;
        end
        else if (om == oms_pkg::OM_COMB_A || om == oms_pkg::OM_COMB_B)
        begin
            target = oms_pkg::OMS_COMBINED;
            forced = 1'b1;
        end
        else if (om == oms_pkg::OM_EXT_FIXED &&
                 su == oms_pkg::SU_NET_PANEL)
        begin
            target = oms_pkg::OMS_NETWORK;
            forced = 1'b1;
        end
        else if (om == oms_pkg::OM_INTERLOCK && !il_on)
        begin
            // forced regardless of the start signal
            target = oms_pkg::OMS_EXTERNAL;
            forced = 1'b1;
        end
        else if (ne_act)
        begin
            active = 1'b1;
            if (ne_on)
                target = oms_pkg::OMS_NETWORK;
            else if (np_asg)
                target = np_on ? oms_pkg::OMS_PANEL :
                                 oms_pkg::OMS_EXTERNAL;
            else
                target = oms_pkg::OMS_EXTERNAL;
            // setting 2 keeps the panel/external input from selecting panel mode
            if (target == oms_pkg::OMS_EXTERNAL && pe_asg && !pe_on &&
                om != oms_pkg::OM_EXT_FIXED)
                target = oms_pkg::OMS_PANEL;
        end
        else if (np_act)
        begin
            active = 1'b1;
            if (np_on)
                target = ne_on ? oms_pkg::OMS_NETWORK :
                                 oms_pkg::OMS_PANEL;
            else if (pe_asg && !pe_on)
                target = oms_pkg::OMS_PANEL;
            else if (pe_asg && om == oms_pkg::OM_INTERLOCK)
                target = oms_pkg::OMS_EXTERNAL;
            else
                target = oms_pkg::OMS_NETWORK;
        end
        else if (om == oms_pkg::OM_EXT_FIXED)
        begin
            target = oms_pkg::OMS_EXTERNAL;
            forced = 1'b1;
        end
        else if (pe_asg && om_np_ok)
        begin
            active = 1'b1;
            target = pe_on ? oms_pkg::OMS_EXTERNAL : oms_pkg::OMS_PANEL;
        end
        if (target == oms_pkg::OMS_NETWORK && no_option)
            target = oms_pkg::OMS_PANEL;
    end

    // mode register: switching waits for stop unless forced or setting 6
    always_comb
    begin
        take = forced || (active && (stopped ||
               om == oms_pkg::OM_RUN_SWITCH));
        mode_next = take ? target : mode_reg;
        stop_next = (om == oms_pkg::OM_INTERLOCK) && il_on &&
                    (mode_next == oms_pkg::OMS_EXTERNAL);
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
        begin
            mode_reg <= oms_pkg::MODE_RST;
            stop_reg <= 1'b0;
        end
        else
        begin
            mode_reg <= mode_next;
            stop_reg <= stop_next;
        end
    end

    assign o_mode = mode_reg;
    assign o_output_stop = stop_reg;
    assign o_switch_open = active && (stopped ||
                           om == oms_pkg::OM_RUN_SWITCH); // handshake-like

    // checks on the registered mode against the cycle that caused it
    chk_panel_fixed: assert property (@(posedge i_ref_clk)
        disable iff (i_sys_rst)
        om == oms_pkg::OM_PANEL_FIXED |=> mode_reg == oms_pkg::OMS_PANEL)
        else $error("setting 1 did not fix panel mode");

    chk_combined_fixed: assert property (@(posedge i_ref_clk)
        disable iff (i_sys_rst)
        (om == oms_pkg::OM_COMB_A || om == oms_pkg::OM_COMB_B)
        |=> mode_reg == oms_pkg::OMS_COMBINED)
        else $error("settings 3/4 did not fix combined mode");

    chk_interlock_force: assert property (@(posedge i_ref_clk)
        disable iff (i_sys_rst)
        (om == oms_pkg::OM_INTERLOCK && !il_on)
        |=> mode_reg == oms_pkg::OMS_EXTERNAL)
        else $error("interlock off did not force external mode");

    chk_run_hold: assert property (@(posedge i_ref_clk)
        disable iff (i_sys_rst)
        (!stopped && om == oms_pkg::OM_SWITCHABLE)
        |=> mode_reg == $past(mode_reg))
        else $error("mode changed while running");

    chk_run_switch: assert property (@(posedge i_ref_clk)
        disable iff (i_sys_rst)
        (!stopped && om == oms_pkg::OM_RUN_SWITCH && ne_act && ne_on &&
         !no_option) |=> mode_reg == oms_pkg::OMS_NETWORK)
        else $error("setting 6 refused switch while running");

    chk_np_panel: assert property (@(posedge i_ref_clk)
        disable iff (i_sys_rst)
        (stopped && np_act && np_on && !ne_on &&
         om == oms_pkg::OM_SWITCHABLE)
        |=> mode_reg == oms_pkg::OMS_PANEL)
        else $error("net/panel input on did not select panel");

    chk_ne_external: assert property (@(posedge i_ref_clk)
        disable iff (i_sys_rst)
        (stopped && ne_act && !ne_on && !np_asg && !pe_asg)
        |=> mode_reg == oms_pkg::OMS_EXTERNAL)
        else $error("net/external off did not select external");

    chk_option_fallback: assert property (@(posedge i_ref_clk)
        disable iff (i_sys_rst)
        (mode_reg != $past(mode_reg) &&
         mode_reg == oms_pkg::OMS_NETWORK) |-> !$past(no_option))
        else $error("network mode entered without fitted option");

    chk_no_panel_two: assert property (@(posedge i_ref_clk)
        disable iff (i_sys_rst)
        (stopped && ne_act && om == oms_pkg::OM_EXT_FIXED && !no_option)
        |=> mode_reg != oms_pkg::OMS_PANEL)
        else $error("setting 2 entered panel mode");

    chk_no_external_ten: assert property (@(posedge i_ref_clk)
        disable iff (i_sys_rst)
        (stopped && np_act && om != oms_pkg::OM_INTERLOCK)
        |=> mode_reg != oms_pkg::OMS_EXTERNAL)
        else $error("startup 10 entered external mode");

    chk_stop_external: assert property (@(posedge i_ref_clk)
        disable iff (i_sys_rst)
        (o_output_stop |-> mode_reg == oms_pkg::OMS_EXTERNAL &&
         $past(om) == oms_pkg::OM_INTERLOCK))
        else $error("output stop outside external mode");

    cov_run_switch: cover property (@(posedge i_ref_clk)
        disable iff (i_sys_rst)
        !stopped && om == oms_pkg::OM_RUN_SWITCH && take &&
        mode_next != mode_reg);

    cov_interlock_drop: cover property (@(posedge i_ref_clk)
        disable iff (i_sys_rst)
        om == oms_pkg::OM_INTERLOCK && il_on ##1 !il_on);

    cov_fallback: cover property (@(posedge i_ref_clk)
        disable iff (i_sys_rst)
        np_act && !np_on && no_option);

    cov_output_stop: cover property (@(posedge i_ref_clk)
        disable iff (i_sys_rst)
        $rose(o_output_stop));

endmodule : oms_mode_select

// >>> tb/oms_terminals.sv
/*
 * oms_terminals: model of the external control terminals that face the
 * mode selector. It places each switching function on a chosen terminal.
 * Assumes the bench drives the four function levels and the assignment
 * mask off the sampling edge.
 */
`timescale 1ns/1ps

module oms_terminals
#(
    parameter int NE_SLOT = 0,
    parameter int NP_SLOT = 1,
    parameter int IL_SLOT = 2,
    parameter int PE_SLOT = 3
)
(
    input wire logic i_net_ext,
    input wire logic i_net_panel,
    input wire logic i_interlock,
    input wire logic i_panel_ext,
    input wire logic [3:0] i_assign,
    output logic [oms_pkg::TERM_N-1:0][oms_pkg::SEL_W-1:0] o_term_sel,
    output logic [oms_pkg::TERM_N-1:0] o_term_pins,
    output logic o_output_stop_pin
);
    // free terminals sit at their pull-up so stray highs must be ignored
    always_comb
    begin
        o_term_sel = '0;
        o_term_pins = '1;
        // a cleared mask bit leaves that terminal unassigned, pin still live
        if (i_assign[3])
            o_term_sel[NE_SLOT] = oms_pkg::FN_NET_EXT;
        o_term_pins[NE_SLOT] = i_net_ext;
        if (i_assign[2])
            o_term_sel[NP_SLOT] = oms_pkg::FN_NET_PANEL;
        o_term_pins[NP_SLOT] = i_net_panel;
        if (i_assign[1])
            o_term_sel[IL_SLOT] = oms_pkg::FN_INTERLOCK;
        o_term_pins[IL_SLOT] = i_interlock;
        if (i_assign[0])
            o_term_sel[PE_SLOT] = oms_pkg::FN_PANEL_EXT;
        o_term_pins[PE_SLOT] = i_panel_ext;
        // no interlock terminal: the stop pin carries the interlock level
        o_output_stop_pin = i_assign[1] ? 1'b0 : i_interlock;
    end
endmodule : oms_terminals

// >>> tb/tb_top.sv
/*
 * tb_top: self-checking bench for the operation mode selector.
 * Assumes the terminal model above and a stopped motor unless a test
 * says otherwise; inputs move on the falling edge.
 */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
    num_errors++; $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end

module tb_top;
    typedef struct packed
    {
        logic [2:0] om;
        logic [3:0] su;
        logic fit;
        logic [3:0] pins;
        oms_pkg::oms_mode_t mode;
        logic stop;
    } oms_row_t;

    logic i_ref_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    oms_pkg::oms_settings_t settings = '{3'h0, 4'h0, 4'h0, 1'h1};
    logic motor_run = 1'b0;
    logic start_cmd = 1'b0;
    logic [3:0] pins = 4'h0; // net_ext, net_panel, interlock, panel_ext
    logic [3:0] fn_map = 4'hF; // which functions have a terminal, same order
    logic [oms_pkg::TERM_N-1:0][oms_pkg::SEL_W-1:0] term_sel;
    logic [oms_pkg::TERM_N-1:0] term_pins;
    logic stop_pin;
    oms_pkg::oms_mode_t mode;
    logic out_stop;
    logic sw_open;
    int num_errors = 0;
    int tests_run = 0;
    oms_row_t rows [20];

    always #5 i_ref_clk = ~i_ref_clk;

    // odd slots prove the function codes, not the positions, route inputs
    oms_terminals #(.NE_SLOT(6), .NP_SLOT(5), .IL_SLOT(0), .PE_SLOT(2)) tm_u
    (
        .i_net_ext(pins[3]), .i_net_panel(pins[2]),
        .i_interlock(pins[1]), .i_panel_ext(pins[0]),
        .i_assign(fn_map),
        .o_term_sel(term_sel), .o_term_pins(term_pins),
        .o_output_stop_pin(stop_pin)
    );

    oms_mode_select dut_u
    (
        .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
        .i_settings(settings), .i_term_sel(term_sel),
        .i_term_pins(term_pins), .i_output_stop_pin(stop_pin),
        .i_motor_running(motor_run), .i_start_cmd(start_cmd),
        .o_mode(mode), .o_output_stop(out_stop), .o_switch_open(sw_open)
    );

    // five edges cover the two-stage synchroniser plus the mode register
    task apply(input logic [2:0] om, input logic [3:0] su, input logic fit,
        input logic [3:0] p);
        @(negedge i_ref_clk);
        settings = '{om, su, 4'h0, fit};
        pins = p;
        repeat (5) @(negedge i_ref_clk);
    endtask : apply

    task check(input string nm, input oms_pkg::oms_mode_t m, input logic s);
        `CHK({nm, " mode"}, m, mode)
        `CHK({nm, " stop"}, s, out_stop)
        $display("test %s done", nm);
    endtask : check

    task finish_test;
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : finish_test

    // about 220 cycles of tests; a hang is cut well beyond that
    initial
    begin
        repeat (3000) @(posedge i_ref_clk);
        num_errors++;
        $display("watchdog expired");
        finish_test();
    end

    initial
    begin
        rows[0] = '{3'h1, 4'hA, 1'h1, 4'h0, oms_pkg::OMS_PANEL, 1'h0};
        rows[1] = '{3'h2, 4'hA, 1'h1, 4'hF, oms_pkg::OMS_NETWORK, 1'h0};
        rows[2] = '{3'h3, 4'hA, 1'h1, 4'hF, oms_pkg::OMS_COMBINED, 1'h0};
        rows[3] = '{3'h4, 4'hA, 1'h1, 4'h0, oms_pkg::OMS_COMBINED, 1'h0};
        rows[4] = '{3'h7, 4'h0, 1'h1, 4'h8, oms_pkg::OMS_EXTERNAL, 1'h0};
        rows[5] = '{3'h0, 4'h0, 1'h1, 4'h9, oms_pkg::OMS_NETWORK, 1'h0};
        rows[6] = '{3'h0, 4'h0, 1'h1, 4'h1, oms_pkg::OMS_EXTERNAL, 1'h0};
        rows[7] = '{3'h0, 4'h0, 1'h1, 4'h5, oms_pkg::OMS_PANEL, 1'h0};
        rows[8] = '{3'h0, 4'h0, 1'h1, 4'h0, oms_pkg::OMS_PANEL, 1'h0};
        rows[9] = '{3'h2, 4'h1, 1'h1, 4'h0, oms_pkg::OMS_EXTERNAL, 1'h0};
        rows[10] = '{3'h0, 4'h0, 1'h0, 4'h9, oms_pkg::OMS_PANEL, 1'h0};
        rows[11] = '{3'h0, 4'hA, 1'h1, 4'h5, oms_pkg::OMS_PANEL, 1'h0};
        rows[12] = '{3'h0, 4'hA, 1'h1, 4'hD, oms_pkg::OMS_NETWORK, 1'h0};
        rows[13] = '{3'h0, 4'hA, 1'h1, 4'h1, oms_pkg::OMS_NETWORK, 1'h0};
        rows[14] = '{3'h0, 4'hA, 1'h1, 4'h0, oms_pkg::OMS_PANEL, 1'h0};
        rows[15] = '{3'h7, 4'hA, 1'h1, 4'h3, oms_pkg::OMS_EXTERNAL, 1'h1};
        rows[16] = '{3'h6, 4'hA, 1'h1, 4'h1, oms_pkg::OMS_NETWORK, 1'h0};
        rows[17] = '{3'h7, 4'h0, 1'h1, 4'h3, oms_pkg::OMS_EXTERNAL, 1'h1};
        rows[18] = '{3'h7, 4'h0, 1'h1, 4'hB, oms_pkg::OMS_NETWORK, 1'h0};
        rows[19] = '{3'h0, 4'hA, 1'h0, 4'h1, oms_pkg::OMS_PANEL, 1'h0};
        repeat (12) @(negedge i_ref_clk);
        check("reset", oms_pkg::OMS_EXTERNAL, 1'b0);
        i_sys_rst = 1'b0;
        // table rows cover fixed, forced and input-driven selections
        foreach (rows[i])
        begin
            apply(rows[i].om, rows[i].su, rows[i].fit, rows[i].pins);
            check($sformatf("row%0d", i), rows[i].mode,
                rows[i].stop);
        end
        // a source other than the option never falls back to panel
        apply(3'h0, 4'h0, 1'h0, 4'h9);
        settings.net_command_source_setting = 4'h1;
        repeat (2) @(negedge i_ref_clk);
        check("src_other", oms_pkg::OMS_NETWORK, 1'b0);
        // running with setting 0: a switch request is held off
        apply(3'h0, 4'h0, 1'h1, 4'h9);
        motor_run = 1'b1;
        start_cmd = 1'b1;
        apply(3'h0, 4'h0, 1'h1, 4'h1);
        check("run_hold", oms_pkg::OMS_NETWORK, 1'b0);
        `CHK("run_hold open", 1'b0, sw_open)
        start_cmd = 1'b0;
        repeat (2) @(negedge i_ref_clk);
        check("start_off", oms_pkg::OMS_EXTERNAL, 1'b0);
        // setting 6 switches with the motor still running
        start_cmd = 1'b1;
        apply(3'h6, 4'h0, 1'h1, 4'h9);
        check("run_sw6_net", oms_pkg::OMS_NETWORK, 1'b0);
        apply(3'h6, 4'h0, 1'h1, 4'h1);
        check("run_sw6_ext", oms_pkg::OMS_EXTERNAL, 1'b0);
        `CHK("run_sw6 open", 1'b1, sw_open)
        // interlock dropping forces external even while running
        motor_run = 1'b0;
        apply(3'h7, 4'h0, 1'h1, 4'hB);
        check("il_net", oms_pkg::OMS_NETWORK, 1'b0);
        motor_run = 1'b1;
        apply(3'h7, 4'h0, 1'h1, 4'h9);
        check("il_drop_run", oms_pkg::OMS_EXTERNAL, 1'b0);
        // unassigned functions are ignored; stop pin stands in for interlock
        motor_run = 1'b0;
        fn_map = 4'hA;
        apply(3'h0, 4'h0, 1'h1, 4'h8);
        check("ne_only_net", oms_pkg::OMS_NETWORK, 1'b0);
        apply(3'h0, 4'h0, 1'h1, 4'h4);
        check("ne_only_ext", oms_pkg::OMS_EXTERNAL, 1'b0);
        fn_map = 4'h3;
        apply(3'h0, 4'h0, 1'h1, 4'h0);
        check("pe_only_panel", oms_pkg::OMS_PANEL, 1'b0);
        fn_map = 4'hD;
        apply(3'h7, 4'h0, 1'h1, 4'hB);
        check("stop_pin_il", oms_pkg::OMS_NETWORK, 1'b0);
        apply(3'h7, 4'h0, 1'h1, 4'h9);
        check("stop_pin_drop", oms_pkg::OMS_EXTERNAL, 1'b0);
        fn_map = 4'hF;
        // second reset in mid-run returns to the power-up mode
        motor_run = 1'b0;
        apply(3'h0, 4'h0, 1'h1, 4'h9);
        i_sys_rst = 1'b1;
        repeat (2) @(negedge i_ref_clk);
        check("rst_mid", oms_pkg::OMS_EXTERNAL, 1'b0);
        i_sys_rst = 1'b0;
        finish_test();
    end
endmodule : tb_top
